// ==== hw/ssfi_pkg.sv ====
// Constants, field positions and types for the switch output and indicator logic
package ssfi_pkg;
  // Channel count and synchroniser width
  localparam int NUM_CH = 4;
  localparam int SYNC_W = 24;
  // Bit positions inside the synchronised input vector
  localparam int POS_CTRL = 0;
  localparam int POS_OE = 4;
  localparam int POS_LOGIC_SIDE_SUPPLY = 5;
  localparam int POS_UV_LO = 6;
  localparam int POS_UV_HI = 7;
  localparam int POS_OT = 8;
  localparam int POS_OV = 12;
  localparam int POS_SD = 16;
  localparam int POS_LOAD = 20;
  // Measurement window for supply and load state changes
  localparam int CLK_PERIOD_NS = 50;
  localparam int MEAS_TIME_NS = 2000;
  localparam int MEAS_CYCLES_I =
    (MEAS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 6;
  localparam logic [CNT_W-1:0] MEAS_LAST = CNT_W'(MEAS_CYCLES_I - 1);
  // Reset values
  localparam logic [SYNC_W-1:0] RST_SYNC = 24'h00_0000;
  localparam logic [CNT_W-1:0] RST_CNT = 6'h00;
  localparam logic [NUM_CH-1:0] RST_CH = 4'h0;
  // Switch-side supply classes
  typedef enum logic [2:0] {
    SUP_NP = 3'b001,
    SUP_W = 3'b010,
    SUP_P = 3'b100
  } ssfi_sup_t;
  // Whole state of the block
  typedef struct packed {
    logic [SYNC_W-1:0] s1;
    logic [SYNC_W-1:0] s2;
    logic [SYNC_W-1:0] s3;
    logic [SYNC_W-1:0] acc;
    logic var_done;
    logic open_var;
    logic fault;
    logic [NUM_CH-1:0] on;
    ssfi_sup_t sup_cand;
    ssfi_sup_t sup_stable;
    ssfi_sup_t sup_prev;
    logic [CNT_W-1:0] sup_cnt;
    logic load_cand;
    logic load_open;
    logic [CNT_W-1:0] load_cnt;
    logic flt_oe_n;
    logic wrn_oe_n;
    logic open_oe_n;
  } ssfi_state_t;
endpackage

// ==== hw/ssfi_core.sv ====
// Channel output, fault, supply warning and open-load indicator logic
`timescale 1ns/10ps
// Function
// - Inputs and device state sampled with equal latency
// - Indicators active-low open-drain, fault released unpowered
// - Switch supply not powered forces fault detected
// - Fault clears by itself when conditions vanish
// - Warning variant: three switch supply classes
// - Warning indicator changes only after measured persistence or a logic-side supply change
// - Over-temperature does not turn on output off
// - Over-temperature blocks an off output turning on
// - Over-voltage leaves outputs behaving normally
// - Any load not detected asserts open-load indicator
// - Open-load indicator changes only after measured persistence or a logic-side supply change
module ssfi_core
  import ssfi_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_clk_en,
  input wire logic i_open_load_variant,
  input wire logic [NUM_CH-1:0] i_channel_control_input,
  input wire logic i_output_enable,
  input wire logic i_logic_side_supply_ok,
  input wire logic i_switch_side_supply_above_lo,
  input wire logic i_switch_side_supply_above_hi,
  input wire logic [NUM_CH-1:0] i_ot_fault,
  input wire logic [NUM_CH-1:0] i_ov_fault,
  input wire logic [NUM_CH-1:0] i_shutdown_fault,
  input wire logic [NUM_CH-1:0] i_load_present,
  output logic [NUM_CH-1:0] o_load_switch_output,
  output logic [NUM_CH-1:0] o_channel_status_indicator_n,
  output logic [NUM_CH-1:0] o_channel_status_indicator_n_oe,
  output logic o_fault_indicator_n,
  output logic o_fault_indicator_n_oe,
  output logic o_switch_supply_warning_n,
  output logic o_switch_supply_warning_n_oe,
  output logic o_open_load_indicator_n,
  output logic o_open_load_indicator_n_oe
);

  ssfi_state_t st_ff;
  ssfi_state_t nxt_st;
  logic [SYNC_W-1:0] pins;
  logic [NUM_CH-1:0] ctrl;
  logic [NUM_CH-1:0] ot;
  logic [NUM_CH-1:0] ov;
  logic [NUM_CH-1:0] sd;
  logic [NUM_CH-1:0] en_raw;
  logic oe;
  logic logic_side_supply;
  ssfi_sup_t sup_raw;
  logic fault_raw;
  logic open_raw;
  logic wrn_on;
  logic open_on;

  // Every pin input except the variant strap shares one synchroniser path
  assign pins = {i_load_present, i_shutdown_fault, i_ov_fault, i_ot_fault,
                 i_switch_side_supply_above_hi, i_switch_side_supply_above_lo,
                 i_logic_side_supply_ok, i_output_enable,
                 i_channel_control_input};

  // Accepted input fields
  assign ctrl = st_ff.acc[POS_CTRL +: NUM_CH];
  assign oe = st_ff.acc[POS_OE];
  assign logic_side_supply = st_ff.acc[POS_LOGIC_SIDE_SUPPLY];
  assign ot = st_ff.acc[POS_OT +: NUM_CH];
  assign ov = st_ff.acc[POS_OV +: NUM_CH];
  assign sd = st_ff.acc[POS_SD +: NUM_CH];

  // Switch supply class from the two thresholds
  // three-level classing
  always_comb begin
    if (!st_ff.acc[POS_UV_LO]) begin
      sup_raw = SUP_NP;
    end else if (st_ff.open_var || st_ff.acc[POS_UV_HI]) begin
      sup_raw = SUP_P;
    end else begin
      sup_raw = SUP_W;
    end
  end

  // Fault state straight from present conditions
  // forced and self-clearing fault
  assign fault_raw = (sup_raw == SUP_NP) | (|sd) | (|ot) | (|ov);

  // Output enable terms; over-voltage deliberately absent
  // over-voltage ignored
  assign en_raw = ctrl & {NUM_CH{oe & logic_side_supply & (sup_raw != SUP_NP)}} & ~sd;

  // Any channel without a load
  // any-channel open load
  assign open_raw = ~&st_ff.acc[POS_LOAD +: NUM_CH];

  // Indicator decisions on the measured states
  always_comb begin
    wrn_on = !st_ff.open_var && logic_side_supply &&
             (st_ff.sup_stable == SUP_W ||
              (st_ff.sup_stable == SUP_NP && st_ff.sup_prev == SUP_W));
    if (st_ff.sup_stable == SUP_NP) begin
      open_on = st_ff.open_var && logic_side_supply && st_ff.load_open &&
                st_ff.sup_prev != SUP_NP;
    end else begin
      open_on = st_ff.open_var && logic_side_supply && st_ff.load_open;
    end
  end

  // Next state
  always_comb begin
    nxt_st = st_ff;
    if (i_clk_en) begin
      nxt_st.s1 = pins;
      nxt_st.s2 = st_ff.s1;
      nxt_st.s3 = st_ff.s2;
      nxt_st.acc = (st_ff.s2 & st_ff.s3) |
                   (st_ff.acc & (st_ff.s2 | st_ff.s3));
      // Variant strap caught once after reset
      if (!st_ff.var_done) begin
        nxt_st.open_var = i_open_load_variant;
        nxt_st.var_done = 1'b1;
      end
      nxt_st.fault = fault_raw;
      nxt_st.on = en_raw & (~ot | st_ff.on);
      if (sup_raw != st_ff.sup_cand) begin
        nxt_st.sup_cand = sup_raw;
        nxt_st.sup_cnt = RST_CNT;
      end else if (st_ff.sup_cnt != MEAS_LAST) begin
        nxt_st.sup_cnt = st_ff.sup_cnt + CNT_W'(1);
      end else if (sup_raw != st_ff.sup_stable) begin
        nxt_st.sup_prev = st_ff.sup_stable;
        nxt_st.sup_stable = sup_raw;
      end
      if (open_raw != st_ff.load_cand) begin
        nxt_st.load_cand = open_raw;
        nxt_st.load_cnt = RST_CNT;
      end else if (st_ff.load_cnt != MEAS_LAST) begin
        nxt_st.load_cnt = st_ff.load_cnt + CNT_W'(1);
      end else begin
        nxt_st.load_open = open_raw;
      end
      nxt_st.flt_oe_n = !(logic_side_supply && fault_raw);
      nxt_st.wrn_oe_n = !wrn_on;
      nxt_st.open_oe_n = !open_on;
    end
  end

  // State register
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      st_ff <= '{s1: RST_SYNC, s2: RST_SYNC, s3: RST_SYNC, acc: RST_SYNC,
                 var_done: 1'b0, open_var: 1'b0, fault: 1'b1, on: RST_CH,
                 sup_cand: SUP_NP, sup_stable: SUP_NP, sup_prev: SUP_NP,
                 sup_cnt: RST_CNT, load_cand: 1'b0, load_open: 1'b0,
                 load_cnt: RST_CNT, flt_oe_n: 1'b1, wrn_oe_n: 1'b1,
                 open_oe_n: 1'b1};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Indicator pins: driven level is always low, enable low means pulling; switch outputs follow the channel state
  assign o_load_switch_output = st_ff.on;
  assign o_channel_status_indicator_n = RST_CH;
  assign o_channel_status_indicator_n_oe = ~st_ff.on;
  assign o_fault_indicator_n = 1'b0;
  assign o_fault_indicator_n_oe = st_ff.flt_oe_n;
  assign o_switch_supply_warning_n = 1'b0;
  assign o_switch_supply_warning_n_oe = st_ff.wrn_oe_n;
  assign o_open_load_indicator_n = 1'b0;
  assign o_open_load_indicator_n_oe = st_ff.open_oe_n;

  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_rst);

  property p_in_latency;
    i_clk_en ##1 i_clk_en ##1 i_clk_en && $stable(st_ff.s2)
      && (st_ff.s2 == st_ff.s3) |=> st_ff.acc == $past(st_ff.s2);
  endproperty
  a_in_latency: assert property (p_in_latency)
    else $error("accepted inputs do not follow agreeing stages");

  property p_unpowered;
    i_clk_en && !logic_side_supply |=> o_fault_indicator_n_oe
      && (&o_channel_status_indicator_n_oe) && o_load_switch_output == 4'h0;
  endproperty
  a_unpowered: assert property (p_unpowered)
    else $error("pins pulled while logic supply down");

  property p_fault_np;
    i_clk_en && sup_raw == SUP_NP |=> st_ff.fault;
  endproperty
  a_fault_np: assert property (p_fault_np)
    else $error("unpowered switch supply without fault");

  property p_fault_clear;
    i_clk_en && !fault_raw |=> !st_ff.fault && o_fault_indicator_n_oe;
  endproperty
  a_fault_clear: assert property (p_fault_clear)
    else $error("fault stays after conditions vanished");

  property p_sup_filter;
    i_clk_en && sup_raw != st_ff.sup_cand |=> $stable(st_ff.sup_stable);
  endproperty
  a_sup_filter: assert property (p_sup_filter)
    else $error("supply class moved without persistence");

  property p_ot_hold;
    i_clk_en && st_ff.on[0] && en_raw[0] |=> o_load_switch_output[0];
  endproperty
  a_ot_hold: assert property (p_ot_hold)
    else $error("channel 0 dropped by over-temperature");

  property p_ot_block;
    i_clk_en && !st_ff.on[0] && ot[0] |=> !o_load_switch_output[0];
  endproperty
  a_ot_block: assert property (p_ot_block)
    else $error("channel 0 turned on during over-temperature");

  property p_ov_normal;
    i_clk_en && en_raw[0] && !ot[0] |=> o_load_switch_output[0]
      && !o_channel_status_indicator_n_oe[0];
  endproperty
  a_ov_normal: assert property (p_ov_normal)
    else $error("channel 0 off although conditions met");

  property p_open_on;
    i_clk_en && st_ff.open_var && logic_side_supply && st_ff.load_open
      && st_ff.sup_stable == SUP_P |=> !o_open_load_indicator_n_oe;
  endproperty
  a_open_on: assert property (p_open_on)
    else $error("open-load indicator not pulled");

  property p_load_filter;
    i_clk_en && open_raw != st_ff.load_cand |=> $stable(st_ff.load_open);
  endproperty
  a_load_filter: assert property (p_load_filter)
    else $error("load state moved without persistence");

  property p_off_cond;
    i_clk_en && !(ctrl[1] && oe) |=> !o_load_switch_output[1]
      && o_channel_status_indicator_n_oe[1];
  endproperty
  a_off_cond: assert property (p_off_cond)
    else $error("channel 1 on without input and enable");

  property p_flt_pin;
    i_clk_en && logic_side_supply && fault_raw |=> !o_fault_indicator_n_oe;
  endproperty
  a_flt_pin: assert property (p_flt_pin)
    else $error("fault indicator not pulled on fault");

endmodule

// ==== testbench/ssfi_host_model.sv ====
// Host controller model driving channel inputs and shared enable
`timescale 1ns/10ps
module ssfi_host_model
  import ssfi_pkg::*;
(
  input wire logic [NUM_CH-1:0] i_req_ch,
  input wire logic i_req_oe,
  output logic [NUM_CH-1:0] o_channel_control_input,
  output logic o_output_enable
);
  // Anything unknown requested is driven low, never left floating
  // defined levels only
  always_comb begin
    for (int k = 0; k < NUM_CH; k++) begin
      o_channel_control_input[k] = (i_req_ch[k] === 1'b1);
    end
    o_output_enable = (i_req_oe === 1'b1);
  end
endmodule

// ==== testbench/testbench.sv ====
// Self-checking bench for the switch output and indicator logic
`timescale 1ns/10ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin failures++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module testbench;
  import ssfi_pkg::*;
  logic clk = 1'b0, rst = 1'b1, strap = 1'b0, oe = 1'b0, logic_side_supply = 1'b1;
  logic lo = 1'b1, hi = 1'b1, cen = 1'b1;
  logic [3:0] ctrl = 4'h0, ot = 4'h0, ov = 4'h0, sd = 4'h0, load = 4'hF;
  logic [3:0] hc, sw, led, led_oe, eon;
  logic hoe, fault_indicator_n, flt_oe, wrn, wrn_oe, opn, opn_oe;
  int failures = 0, num_checks = 0;
  // Clock of 50 ns
  always #25 clk = ~clk;
  ssfi_host_model i_ssfi_host_model (.i_req_ch(ctrl), .i_req_oe(oe),
    .o_channel_control_input(hc), .o_output_enable(hoe));
  ssfi_core i_ssfi_core (.i_sys_clk(clk), .i_rst(rst), .i_clk_en(cen),
    .i_open_load_variant(strap), .i_channel_control_input(hc),
    .i_output_enable(hoe), .i_logic_side_supply_ok(logic_side_supply),
    .i_switch_side_supply_above_lo(lo), .i_switch_side_supply_above_hi(hi),
    .i_ot_fault(ot), .i_ov_fault(ov), .i_shutdown_fault(sd),
    .i_load_present(load), .o_load_switch_output(sw),
    .o_channel_status_indicator_n(led),
    .o_channel_status_indicator_n_oe(led_oe), .o_fault_indicator_n(fault_indicator_n),
    .o_fault_indicator_n_oe(flt_oe), .o_switch_supply_warning_n(wrn),
    .o_switch_supply_warning_n_oe(wrn_oe), .o_open_load_indicator_n(opn),
    .o_open_load_indicator_n_oe(opn_oe));
  task automatic report_and_stop;
    if (failures == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Reset for 3 cycles with the strap held
  task automatic do_reset(input logic v);
    rst = 1'b1;
    strap = v;
    eon = 4'h0;
    step(3);
    rst = 1'b0;
    step(8);
  endtask
  // Expected switch state; over-temperature only blocks turn-on
  function automatic logic [3:0] exp_on(input logic [3:0] prev);
    logic g;
    g = oe & logic_side_supply & lo;
    return ctrl & {4{g}} & ~sd & (prev | ~ot);
  endfunction
  // Settle, then compare outputs and wire levels
  task automatic chk_main;
    step(8);
    eon = exp_on(eon);
    `CHK(sw, eon)
    `CHK(led_oe | led, ~eon)
    `CHK(flt_oe | fault_indicator_n, ~(logic_side_supply & (~lo | |sd | |ot | |ov)))
    `CHK({led, fault_indicator_n, wrn, opn}, 7'h00)
  endtask
  initial begin
    void'($urandom(98));
    do_reset(1'b0);
    oe = 1'b1;
    ctrl = 4'hF;
    chk_main();
    // Clock enable low freezes inputs and outputs
    cen = 1'b0;
    ctrl = 4'h0;
    step(8);
    `CHK(sw, eon)
    ctrl = 4'hF;
    cen = 1'b1;
    ot = 4'h3;
    chk_main();
    ctrl = 4'h0;
    chk_main();
    ctrl = 4'hF;
    chk_main();
    `CHK(sw, 4'hC)
    ot = 4'h0;
    ov = 4'hF;
    chk_main();
    `CHK(sw, 4'hF)
    ov = 4'h0;
    lo = 1'b0;
    chk_main();
    `CHK(flt_oe, 1'b0)
    lo = 1'b1;
    chk_main();
    `CHK(flt_oe, 1'b1)
    // Warning class, brief then held
    hi = 1'b0;
    step(30);
    `CHK(wrn_oe, 1'b1)
    hi = 1'b1;
    step(60);
    `CHK(wrn_oe, 1'b1)
    hi = 1'b0;
    step(60);
    `CHK(wrn_oe, 1'b0)
    `CHK(sw, 4'hF)
    // Not powered after warning keeps the warning shown
    lo = 1'b0;
    step(60);
    `CHK(wrn_oe, 1'b0)
    `CHK({sw, flt_oe}, 5'h00)
    lo = 1'b1;
    step(60);
    `CHK(wrn_oe, 1'b0)
    hi = 1'b1;
    step(60);
    `CHK(wrn_oe, 1'b1)
    // Random mix, equal input timing
    repeat (150) begin
      ctrl = 4'($urandom);
      oe = ($urandom_range(3) != 0);
      logic_side_supply = ($urandom_range(7) != 0);
      lo = ($urandom_range(7) != 0);
      hi = 1'($urandom);
      ot = 4'($urandom) & 4'($urandom);
      ov = 4'($urandom) & 4'($urandom);
      sd = 4'($urandom) & 4'($urandom) & 4'($urandom);
      chk_main();
    end
    logic_side_supply = 1'b1;
    lo = 1'b1;
    {ot, ov, sd} = 12'h000;
    // Open-load variant
    do_reset(1'b1);
    // Let the supply class settle before the load excursion
    step(40);
    load = 4'hE;
    step(30);
    `CHK(opn_oe, 1'b1)
    load = 4'hF;
    step(60);
    `CHK(opn_oe, 1'b1)
    load = 4'hB;
    step(60);
    `CHK(opn_oe | opn, 1'b0)
    hi = 1'b0;
    load = 4'hF;
    step(60);
    `CHK({opn_oe, wrn_oe}, 2'h3)
    report_and_stop();
  end
  // Watchdog well beyond the expected run
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    report_and_stop();
  end
endmodule
